// file: hdl/cecb_code_error_counter_bank.sv
// Purpose: clear-on-read code error counters behind a management port
// Assumes: error inputs are toggles from serial-rate logic; mdc slow
// Notes:   pattern selection lives in the checkers feeding the toggles
`default_nettype none
// Functional notes
// - functional mode, high-speed counter counts invalid and disparity words.
// - in KR mode reading high-speed counter clears status low byte.
// - high-speed counter resets to 0xFFFD, or zero in KR mode.
// - high-speed test verify counts errors of pattern chosen by 1E.000B[10:8].
// - pseudo-random pin set, high-speed counter counts its bit errors.
// - every counter returns its value on read, then clears.
// - KR and KX modes, lane counters count lane decoder errors.
// - plain 10G mode, lane counters count alignment slave decoder errors.
// - low-speed test verify counts errors of pattern chosen by 1E.000B[5:4].
// - lane counters at 0x11, 0x12, 0x13, reset 0xFFFD.
// - bad codeword flag latches high until read.
module cecb_code_error_counter_bank
   import cecb_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // management pins
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe,
   input  wire logic [4:0] port_addr,
   // mode pins
   input  wire logic       mode_kr,
   input  wire logic       mode_10g,
   input  wire logic       hs_test_verify,
   input  wire logic       ls_test_verify,
   input  wire logic       pseudo_random_check_pin,
   // error toggles
   input  wire logic       hs_decode_err_tgl,
   input  wire logic       hs_pattern_err_tgl,
   input  wire logic       hs_prbs_err_tgl,
   input  wire logic [2:0] ls_decode_err_tgl,
   input  wire logic [2:0] ls_align_err_tgl,
   input  wire logic [2:0] ls_pattern_err_tgl,
   // status side
   output logic            fast_side_bad_codeword_flag,
   output logic            kr_status_low_clear
);
   // ==========================================================
   // synchronisers
   localparam int NT = 12;
   localparam int NL = 11;
   logic [NT-1:0] tgl_q1, tgl_q2, tgl_q3;
   logic [NL-1:0] lvl_q1, lvl_q2;
   logic [NT-1:0] evt;
   logic [2:0]    mdc_q;
   logic          kr_q, g10_q, hs_tv_q, ls_tv_q, prbs_q, bit_in;
   logic [4:0]    port_q;
   logic          mdc_rise;

   always_ff @(posedge clk) begin
      tgl_q1 <= {ls_pattern_err_tgl, ls_align_err_tgl, ls_decode_err_tgl,
                 hs_prbs_err_tgl, hs_pattern_err_tgl, hs_decode_err_tgl};
      tgl_q2 <= tgl_q1;
      tgl_q3 <= tgl_q2;
      lvl_q1 <= {port_addr, mdio_in, pseudo_random_check_pin,
                 ls_test_verify, hs_test_verify, mode_10g, mode_kr};
      lvl_q2 <= lvl_q1;
      mdc_q  <= {mdc_q[1:0], mdc};
   end

   assign evt      = tgl_q2 ^ tgl_q3;
   assign kr_q     = lvl_q2[0];
   assign g10_q    = lvl_q2[1];
   assign hs_tv_q  = lvl_q2[2];
   assign ls_tv_q  = lvl_q2[3];
   assign prbs_q   = lvl_q2[4];
   assign bit_in   = lvl_q2[5];
   assign port_q   = lvl_q2[10:6];
   assign mdc_rise = mdc_q[1] & ~mdc_q[2];

   // ==========================================================
   // event selection
   logic [3:0] cnt_evt;
   logic [3:0] rd_clr;
   always_comb begin
      if (prbs_q)
         cnt_evt[0] = evt[2];
      else if (hs_tv_q)
         cnt_evt[0] = evt[1];
      else
         cnt_evt[0] = evt[0];
      for (int i = 0; i < 3; i++) begin
         if (ls_tv_q)
            cnt_evt[i+1] = evt[9+i];
         else if (g10_q)
            cnt_evt[i+1] = evt[6+i];
         else
            cnt_evt[i+1] = evt[3+i];
      end
   end

   // ==========================================================
   // counters
   logic [15:0] cnt_reg [4];
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_cnt
         always_ff @(posedge clk) begin
            if (sys_rst)
               cnt_reg[g] <= (g == 0 && kr_q) ? CECB_CNT_KR_RESET
                                              : CECB_CNT_RESET;
            else if (rd_clr[g])
               cnt_reg[g] <= {15'h0000, cnt_evt[g]};
            else if (cnt_evt[g] && cnt_reg[g] != CECB_CNT_MAX)
               cnt_reg[g] <= cnt_reg[g] + 16'h0001;
         end
      end
   endgenerate

   // ==========================================================
   // management frame engine
   cecb_state_e state_reg;
   logic [5:0]  ones_reg;
   logic [4:0]  bit_cnt_reg;
   logic [11:0] hdr_sh_reg;
   cecb_hdr_s   hdr;
   logic [15:0] addr_reg, rd_sh_reg, wr_sh_reg;
   logic        hit_reg, rd_reg, inc_reg, adr_op_reg, flag_clr;
   logic        hdr_hit, hdr_rd;
   logic [15:0] rd_val;

   assign hdr     = cecb_hdr_s'({hdr_sh_reg, bit_in});
   assign hdr_hit = !hdr.st_low && hdr.prtad == port_q
                    && hdr.devad == CECB_DEVAD;
   assign hdr_rd  = hdr.op == CECB_OP_READ || hdr.op == CECB_OP_READ_INC;

   always_comb begin
      rd_val = 16'h0000;
      case (addr_reg)
         CECB_STATUS_ADDR:
            rd_val[CECB_BAD_CW_BIT] = fast_side_bad_codeword_flag;
         CECB_HS_ADDR:    rd_val = cnt_reg[0];
         CECB_LANE0_ADDR: rd_val = cnt_reg[1];
         CECB_LANE1_ADDR: rd_val = cnt_reg[2];
         CECB_LANE2_ADDR: rd_val = cnt_reg[3];
         default:         rd_val = 16'h0000;
      endcase
   end

   // read is taken when the header ends; clears fire the same cycle
   logic rd_take;
   assign rd_take = mdc_rise && state_reg == CECB_ST_HDR
                    && bit_cnt_reg == CECB_HDR_LAST && hdr_hit && hdr_rd;
   always_comb begin
      for (int i = 0; i < 4; i++)
         rd_clr[i] = rd_take
                     && addr_reg == CECB_HS_ADDR + 16'(i);
      flag_clr = rd_take && addr_reg == CECB_STATUS_ADDR;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg   <= CECB_ST_PRE;
         ones_reg    <= 6'h00;
         bit_cnt_reg <= 5'h00;
         hdr_sh_reg  <= 12'h000;
         addr_reg    <= 16'h0000;
         rd_sh_reg   <= 16'h0000;
         wr_sh_reg   <= 16'h0000;
         hit_reg     <= 1'b0;
         rd_reg      <= 1'b0;
         inc_reg     <= 1'b0;
         adr_op_reg  <= 1'b0;
         mdio_out    <= 1'b0;
         mdio_oe     <= 1'b0;
      end else if (mdc_rise) begin
         case (state_reg)
            CECB_ST_PRE: begin
               if (bit_in) begin
                  if (ones_reg != CECB_PRE_ONES)
                     ones_reg <= ones_reg + 6'h01;
               end else begin
                  ones_reg <= 6'h00;
                  if (ones_reg == CECB_PRE_ONES) begin
                     state_reg   <= CECB_ST_HDR;
                     bit_cnt_reg <= 5'h00;
                  end
               end
            end
            CECB_ST_HDR: begin
               hdr_sh_reg  <= {hdr_sh_reg[10:0], bit_in};
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == CECB_HDR_LAST) begin
                  state_reg   <= CECB_ST_TA;
                  bit_cnt_reg <= 5'h00;
                  hit_reg     <= hdr_hit;
                  rd_reg      <= hdr_rd;
                  inc_reg     <= hdr.op == CECB_OP_READ_INC;
                  rd_sh_reg   <= rd_val;
                  adr_op_reg  <= hdr.op == CECB_OP_ADDR;
               end
            end
            CECB_ST_TA: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == 5'h00) begin
                  mdio_oe  <= hit_reg && rd_reg;
                  mdio_out <= 1'b0;
               end else begin
                  state_reg   <= CECB_ST_DATA;
                  bit_cnt_reg <= 5'h00;
                  mdio_out    <= rd_sh_reg[15];
                  rd_sh_reg   <= {rd_sh_reg[14:0], 1'b0};
               end
            end
            CECB_ST_DATA: begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
               wr_sh_reg   <= {wr_sh_reg[14:0], bit_in};
               mdio_out    <= rd_sh_reg[15];
               rd_sh_reg   <= {rd_sh_reg[14:0], 1'b0};
               if (bit_cnt_reg == CECB_DATA_LAST) begin
                  state_reg <= CECB_ST_PRE;
                  mdio_oe   <= 1'b0;
                  mdio_out  <= 1'b0;
                  if (hit_reg && adr_op_reg)
                     addr_reg <= {wr_sh_reg[14:0], bit_in};
                  else if (hit_reg && inc_reg)
                     addr_reg <= addr_reg + 16'h0001;
               end
            end
            default: state_reg <= CECB_ST_PRE;
         endcase
      end
   end

   // ==========================================================
   // status side effects
   always_ff @(posedge clk) begin
      if (sys_rst)
         fast_side_bad_codeword_flag <= 1'b0;
      else if (evt[0])
         fast_side_bad_codeword_flag <= 1'b1;
      else if (flag_clr)
         fast_side_bad_codeword_flag <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         kr_status_low_clear <= 1'b0;
      else
         kr_status_low_clear <= rd_clr[0] && kr_q;
   end

   // ==========================================================
   // assertions
   a_sat_hold: assert property (@(posedge clk) disable iff (sys_rst)
      cnt_reg[0] == CECB_CNT_MAX && !rd_clr[0] |=> cnt_reg[0] == CECB_CNT_MAX)
      else $error("counter left saturation without read");
   a_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
      rd_clr[1] && !cnt_evt[1] |=> cnt_reg[1] == 16'h0000)
      else $error("lane counter not cleared by read");
   a_clear_keeps_evt: assert property (@(posedge clk)
      disable iff (sys_rst) rd_clr[0] && cnt_evt[0] |=> cnt_reg[0] == 16'h0001)
      else $error("event lost during read clear");
   a_hs_count_step: assert property (@(posedge clk) disable iff (sys_rst)
      !prbs_q && !hs_tv_q && evt[0] && !rd_clr[0] && cnt_reg[0] != CECB_CNT_MAX
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
      else $error("decoder error not counted");
   a_kr_status_clr: assert property (@(posedge clk) disable iff (sys_rst)
      rd_clr[0] && kr_q |=> kr_status_low_clear ##1 !kr_status_low_clear)
      else $error("kr status clear pulse wrong");
   a_lane_reset_val: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst ##1 !sys_rst |-> cnt_reg[1] == CECB_CNT_RESET
                               && cnt_reg[3] == CECB_CNT_RESET)
      else $error("lane counter reset value wrong");
   a_hs_reset_val: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst && $stable(kr_q) ##1 !sys_rst |-> cnt_reg[0] ==
         ($past(kr_q) ? CECB_CNT_KR_RESET : CECB_CNT_RESET))
      else $error("hs counter reset value wrong");
   a_flag_latch: assert property (@(posedge clk) disable iff (sys_rst)
      evt[0] |=> fast_side_bad_codeword_flag until flag_clr)
      else $error("bad codeword flag not held");
   a_prbs_count: assert property (@(posedge clk) disable iff (sys_rst)
      prbs_q && evt[2] && !rd_clr[0] && cnt_reg[0] != CECB_CNT_MAX
      |=> cnt_reg[0] != $past(cnt_reg[0]))
      else $error("pseudo-random error not counted");
   a_ta_drive_low: assert property (@(posedge clk) disable iff (sys_rst)
      mdc_rise && state_reg == CECB_ST_TA && bit_cnt_reg == 5'h00
      && hit_reg && rd_reg |=> mdio_oe && !mdio_out)
      else $error("turnaround not driven low");

   c_hs_read: cover property (@(posedge clk) disable iff (sys_rst)
      rd_clr[0]);
   c_saturate: cover property (@(posedge clk) disable iff (sys_rst)
      cnt_reg[1] == CECB_CNT_MAX && cnt_evt[1]);
   c_read_with_evt: cover property (@(posedge clk) disable iff (sys_rst)
      rd_clr[0] && cnt_evt[0]);
endmodule
`default_nettype wire

// file: hdl/cecb_pkg.sv
// Purpose: constants and types for the code error counter bank
// Assumes: management frames of the clause 45 kind, sampled on clk
// Notes:   offsets are register addresses inside device 0x1E
`default_nettype none
package cecb_pkg;
   // ==========================================================
   // register map
   localparam logic [4:0]  CECB_DEVAD        = 5'h1E;
   localparam logic [15:0] CECB_STATUS_ADDR  = 16'h000F;
   localparam logic [15:0] CECB_HS_ADDR      = 16'h0010;
   localparam logic [15:0] CECB_LANE0_ADDR   = 16'h0011;
   localparam logic [15:0] CECB_LANE1_ADDR   = 16'h0012;
   localparam logic [15:0] CECB_LANE2_ADDR   = 16'h0013;
   localparam int          CECB_BAD_CW_BIT   = 8;
   localparam logic [15:0] CECB_CNT_RESET    = 16'hFFFD;
   localparam logic [15:0] CECB_CNT_KR_RESET = 16'h0000;
   localparam logic [15:0] CECB_CNT_MAX      = 16'hFFFF;
   // ==========================================================
   // frame layout
   localparam logic [5:0]  CECB_PRE_ONES     = 6'h20;
   localparam logic [4:0]  CECB_HDR_LAST     = 5'h0C;
   localparam logic [4:0]  CECB_DATA_LAST    = 5'h0F;
   localparam logic [1:0]  CECB_OP_ADDR      = 2'h0;
   localparam logic [1:0]  CECB_OP_WRITE     = 2'h1;
   localparam logic [1:0]  CECB_OP_READ_INC  = 2'h2;
   localparam logic [1:0]  CECB_OP_READ      = 2'h3;

   typedef struct packed {
      logic       st_low;
      logic [1:0] op;
      logic [4:0] prtad;
      logic [4:0] devad;
   } cecb_hdr_s;

   typedef enum logic [1:0] {
      CECB_ST_PRE  = 2'b00,
      CECB_ST_HDR  = 2'b01,
      CECB_ST_TA   = 2'b10,
      CECB_ST_DATA = 2'b11
   } cecb_state_e;
endpackage
`default_nettype wire

// file: bench/cecb_station.sv
// Purpose: management station model that frames reads and addresses
// Assumes: bench resolves the data line, with a pull-up when released
// Notes:   mdc stands high between frames, 10 clk per phase
`default_nettype none
module cecb_station
#(
   parameter logic [4:0] PORT = 5'h03
)
(
   // clock
   input  wire logic clk,
   // management pins
   output logic      mdc,
   output logic      drv,
   output logic      drv_en,
   input  wire logic line
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      mdc    = 1'b1;
      drv    = 1'b1;
      drv_en = 1'b0;
   end

   // ==========================================================
   // one frame; rd holds turnaround bit then 16 data bits
   task automatic frame(input  logic [1:0]  op,
                        input  logic [4:0]  dev,
                        input  logic [15:0] data,
                        output logic [16:0] rd);
      logic [63:0] seq;
      seq = {32'hFFFF_FFFF, 2'b00, op, PORT, dev, 2'b10, data};
      rd  = 17'h0_0000;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk);
         mdc    <= 1'b0;
         drv    <= seq[63 - i];
         drv_en <= !(op[1] && i >= 46);
         repeat (10) @(negedge clk);
         mdc <= 1'b1;
         if (i >= 47) rd = {rd[15:0], line};
         repeat (9) @(negedge clk);
      end
      drv_en <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/cecb_code_error_counter_bank_bench.sv
// Purpose: self-checking bench for the code error counter bank
// Assumes: one port address strap, station model on the mdio pins
// Notes:   counts start at reset values, then are read back to zero
`default_nettype none
module cecb_code_error_counter_bank_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import cecb_pkg::*;

   logic        clk      = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        mode_kr  = 1'b0;
   logic        mode_10g = 1'b0;
   logic        hs_tv    = 1'b0;
   logic        ls_tv    = 1'b0;
   logic        prbs_pin = 1'b0;
   logic        hs_dec   = 1'b0;
   logic        hs_pat   = 1'b0;
   logic        hs_prbs  = 1'b0;
   logic [2:0]  ls_dec   = 3'h0;
   logic [2:0]  ls_aln   = 3'h0;
   logic [2:0]  ls_pat   = 3'h0;
   logic [4:0]  port_strap = 5'h03;
   logic        mdc, mdio_out, mdio_oe, st_drv, st_en, flag, kr_clr;
   wire  logic  mdio_line;
   int          n_mismatch = 0;
   int          checks     = 0;
   int          kr_pulses  = 0;
   int          oe_cnt     = 0;

   always #2 clk = ~clk;
   // pull-up on the shared data line
   assign mdio_line = mdio_oe ? mdio_out : (st_en ? st_drv : 1'b1);
   always @(negedge clk) if (kr_clr === 1'b1) kr_pulses++;
   always @(negedge clk) if (mdio_oe === 1'b1) oe_cnt++;

   cecb_code_error_counter_bank cecb_code_error_counter_bank_inst (
      .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_line),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr(port_strap),
      .mode_kr(mode_kr), .mode_10g(mode_10g), .hs_test_verify(hs_tv),
      .ls_test_verify(ls_tv), .pseudo_random_check_pin(prbs_pin),
      .hs_decode_err_tgl(hs_dec), .hs_pattern_err_tgl(hs_pat),
      .hs_prbs_err_tgl(hs_prbs), .ls_decode_err_tgl(ls_dec),
      .ls_align_err_tgl(ls_aln), .ls_pattern_err_tgl(ls_pat),
      .fast_side_bad_codeword_flag(flag), .kr_status_low_clear(kr_clr));

   cecb_station #(.PORT(5'h03)) cecb_station_inst (
      .clk(clk), .mdc(mdc), .drv(st_drv), .drv_en(st_en),
      .line(mdio_line));

   // ==========================================================
   // shared tasks
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic acc(input logic [1:0] op, input logic [15:0] a,
                      output logic [16:0] r);
      cecb_station_inst.frame(op, CECB_DEVAD, a, r);
   endtask

   // four counters via post-increment reads
   task automatic sweep(input logic [15:0] e0, e1, e2, e3);
      logic [16:0] r;
      logic [15:0] e [4];
      e = '{e0, e1, e2, e3};
      acc(CECB_OP_ADDR, CECB_HS_ADDR, r);
      for (int i = 0; i < 4; i++) begin
         acc(CECB_OP_READ_INC, 16'h0000, r);
         check(r, {1'b0, e[i]});
      end
   endtask

   // sources get 1, 2 and 4 events
   task automatic burst();
      for (int i = 0; i < 4; i++) begin
         repeat (2) @(negedge clk);
         hs_dec  ^= (i < 1);
         hs_pat  ^= (i < 2);
         hs_prbs ^= 1'b1;
         ls_dec  ^= (i < 1) ? 3'h7 : 3'h0;
         ls_aln  ^= (i < 2) ? 3'h7 : 3'h0;
         ls_pat  ^= 3'h7;
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_saturate();
      for (int i = 0; i < 3; i++) begin
         repeat (2) @(negedge clk);
         ls_dec ^= (i == 0) ? 3'h3 : 3'h1;
      end
      repeat (8) @(negedge clk);
      sweep(16'hFFFD, 16'hFFFF, 16'hFFFE, 16'hFFFD);
      sweep(16'h0000, 16'h0000, 16'h0000, 16'h0000);
   endtask

   task automatic t_sources();
      logic [3:0]  m  [3] = '{4'b0000, 4'b0110, 4'b1101};
      logic [15:0] eh [3] = '{16'h0001, 16'h0002, 16'h0004};
      logic [15:0] el [3] = '{16'h0001, 16'h0004, 16'h0002};
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         {prbs_pin, hs_tv, ls_tv, mode_10g} = m[k];
         repeat (4) @(negedge clk);
         burst();
         sweep(eh[k], el[k], el[k], el[k]);
      end
   endtask

   task automatic t_kr();
      logic [16:0] r;
      int          oe0;
      check(17'(kr_pulses), 17'h0_0000);
      @(negedge clk);
      {prbs_pin, hs_tv, ls_tv, mode_10g} = 4'b0000;
      mode_kr = 1'b1;
      sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
      hs_dec ^= 1'b1;
      repeat (8) @(negedge clk);
      check({16'h0000, flag}, 17'h0_0001);
      acc(CECB_OP_ADDR, CECB_HS_ADDR, r);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h0_0001);
      check(17'(kr_pulses), 17'h0_0001);
      // event lands on the edge that takes the read
      fork
         acc(CECB_OP_READ, 16'h0000, r);
         begin
            repeat (911) @(negedge clk);
            hs_dec ^= 1'b1;
         end
      join
      check(r, 17'h0_0000);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h0_0001);
      acc(CECB_OP_ADDR, CECB_STATUS_ADDR, r);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h0_0100);
      check({16'h0000, flag}, 17'h0_0000);
      acc(CECB_OP_ADDR, CECB_LANE0_ADDR, r);
      acc(CECB_OP_WRITE, 16'h1234, r);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h0_FFFD);
      oe0 = oe_cnt;
      cecb_station_inst.frame(CECB_OP_READ, 5'h01, 16'h0000, r);
      check(r, 17'h1_FFFF);
      check(17'(oe_cnt - oe0), 17'h0_0000);
      port_strap = 5'h04;
      repeat (4) @(negedge clk);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h1_FFFF);
      check(17'(oe_cnt - oe0), 17'h0_0000);
      port_strap = 5'h03;
      acc(CECB_OP_ADDR, 16'h0020, r);
      acc(CECB_OP_READ, 16'h0000, r);
      check(r, 17'h0_0000);
   endtask

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      t_saturate();
      t_sources();
      t_kr();
      summarize();
   end

   // watchdog, about twice the expected run
   initial begin
      #400us;
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
